/* File: core/acfg_pkg.sv */
// constants for the analog configuration command interpreter
`default_nettype none
package acfg_pkg;
  // --------------------------------------------------------------------
  // command codes and frame bytes
  // --------------------------------------------------------------------
  localparam logic [7:0] CMD_PROTO = 8'h02;
  localparam logic [7:0] CMD_RDREG = 8'h08;
  localparam logic [7:0] CMD_REGISTER_WRITE_CMD = 8'h09;
  localparam logic [7:0] ADDR_WR = 8'h68;
  localparam logic [7:0] ADDR_RD = 8'h69;
  localparam logic [7:0] LEN_SHORT = 8'h03;
  localparam logic [7:0] LEN_LONG = 8'h04;
  localparam logic [7:0] LEN_RD = 8'h03;
  localparam logic [7:0] FLAG_NOINC = 8'h00;
  localparam logic [7:0] FLAG_INC = 8'h01;
  localparam logic [2:0] BODY_MAX = 3'h4;
  // --------------------------------------------------------------------
  // register indices
  // --------------------------------------------------------------------
  localparam logic [7:0] IDX_RDR = 8'h01;
  localparam logic [7:0] IDX_CE = 8'h04;
  localparam logic [7:0] IDX_RESET = 8'h01;
  // --------------------------------------------------------------------
  // reply bytes
  // --------------------------------------------------------------------
  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_ERR_LEN = 8'h82;
  localparam logic [7:0] RES_LEN_ZERO = 8'h00;
  localparam logic [7:0] RES_RD_TAG = 8'h01;
  // --------------------------------------------------------------------
  // protocol codes carried by the protocol-select command
  // --------------------------------------------------------------------
  localparam logic [7:0] PROTO_15693 = 8'h01;
  localparam logic [7:0] PROTO_14443A = 8'h02;
  localparam logic [7:0] PROTO_14443B = 8'h03;
  localparam logic [7:0] PROTO_18092 = 8'h04;
  localparam logic [7:0] PROTO_CE_A = 8'h12;
  localparam int PARAM_DEPTH100_BIT = 4;
  // --------------------------------------------------------------------
  // reset and default values
  // --------------------------------------------------------------------
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] DEF_RDR_A = 8'hdf;
  localparam logic [7:0] DEF_RDR_B = 8'h2f;
  localparam logic [7:0] DEF_RDR_18092 = 8'h5f;
  localparam logic [7:0] DEF_RDR_15693_30 = 8'h53;
  localparam logic [7:0] DEF_RDR_15693_100 = 8'hd3;
  localparam logic [7:0] DEF_CE_A = 8'h27;
  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int MOD_LSB = 4;
  localparam int GAIN_LSB = 0;
  localparam int LOADMOD_LSB = 0;
  localparam int SENS_LSB = 4;
  // --------------------------------------------------------------------
  // frame parser states
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_CMD = 3'b001,
    ST_LEN = 3'b010,
    ST_BODY = 3'b100
  } acfg_state_t;
endpackage
`default_nettype wire

/* File: core/acfg_regs.sv */
// storage for the two analog configuration registers
`default_nettype none
module acfg_regs
  import acfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rdr_ld,
  input wire logic [7:0] rdr_ld_val,
  input wire logic ce_ld,
  input wire logic [7:0] ce_ld_val,
  input wire logic rdr_we,
  input wire logic ce_we,
  input wire logic [7:0] wdata,
  input wire logic [7:0] sel,
  output logic [7:0] rd_data,
  output logic [7:0] rdr_val,
  output logic [7:0] ce_val
);
  logic [7:0] rdr_q, rdr_d, ce_q, ce_d, rd_q, rd_d;

  assign rdr_d = rdr_we ? wdata : (rdr_ld ? rdr_ld_val : rdr_q);
  assign ce_d = ce_we ? wdata : (ce_ld ? ce_ld_val : ce_q);
  assign rd_d = (sel == IDX_CE) ? ce_q : ((sel == IDX_RDR) ? rdr_q : 8'h00);

  // contents lost at power off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdr_q <= CFG_RESET;
      ce_q <= CFG_RESET;
      rd_q <= 8'h00;
    end else begin
      rdr_q <= rdr_d;
      ce_q <= ce_d;
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;
  assign rdr_val = rdr_q;
  assign ce_val = ce_q;
endmodule
`default_nettype wire

/* File: core/acfg_cmd_top.sv */
// command interpreter for the analog configuration registers
`default_nettype none
// Overview of operation
// - protocol select loads defaults; later register writes may overwrite them.
// - a written value holds until the next write to it or a protocol select that loads its default.
// - both configuration registers clear at power off.
// - write frame is 09, length 03/04, address 68, flag, data bytes.
// - index 04 with flag clear points at the card-emulation register.
// - index 01 with flag clear points at the reader register.
// - four-byte form with flag one: index byte, then new value byte.
// - successful write replies result 00 then length 00.
// - read frame 0803690100 returns 01 then the pointed register value.
// - reader register: modulation code high nibble, receiver gain low nibble.
// - modulation codes 1-6 and D select 10 to 95 percent.
// - gain codes 0,1,3,7,F select 34,32,27,20,8 dB.
// - card register bits 3..0 set load modulation, 1 min, 7 default, F max.
// - card register bits 5..4 set demodulator sensitivity, 1=10%, 2=100%.
// - reader defaults DF, 2F, 5F, 53, D3 per selected protocol.
// - card-emulation Type A select loads 27 into the card register.
module acfg_cmd_top
  import acfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic tx_last,
  output logic [7:0] tx_data,
  output logic [7:0] reader_cfg,
  output logic [7:0] card_cfg,
  output logic [3:0] mod_index_code,
  output logic [3:0] rx_gain_code,
  output logic [3:0] load_mod_code,
  output logic [1:0] demod_sens_code,
  output logic [6:0] mod_percent,
  output logic [5:0] rx_gain_db
);
  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic idx_ok(input logic [7:0] idx);
    idx_ok = (idx == IDX_RDR) || (idx == IDX_CE);
  endfunction

  function automatic logic [6:0] mod_pct(input logic [3:0] code);
    case (code)
      4'h1: mod_pct = 7'd10;
      4'h2: mod_pct = 7'd17;
      4'h3: mod_pct = 7'd25;
      4'h4: mod_pct = 7'd30;
      4'h5: mod_pct = 7'd33;
      4'h6: mod_pct = 7'd36;
      4'hd: mod_pct = 7'd95;
      default: mod_pct = 7'd0;
    endcase
  endfunction

  function automatic logic [5:0] gain_db(input logic [3:0] code);
    case (code)
      4'h0: gain_db = 6'd34;
      4'h1: gain_db = 6'd32;
      4'h3: gain_db = 6'd27;
      4'h7: gain_db = 6'd20;
      4'hf: gain_db = 6'd8;
      default: gain_db = 6'd0;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // frame parser
  // --------------------------------------------------------------------
  acfg_state_t st_q, st_d;
  logic [7:0] cmd_q, len_q, cnt_q;
  logic [7:0] body_q [BODY_MAX];
  logic exec_q, exec_d;
  logic [7:0] ptr_q;
  logic take_cmd, take_len, take_body, body_done;
  logic [7:0] cnt_nxt;

  assign take_cmd = rx_valid && (rx_sof || st_q == ST_CMD);
  assign take_len = rx_valid && !rx_sof && st_q == ST_LEN;
  assign take_body = rx_valid && !rx_sof && st_q == ST_BODY;
  assign cnt_nxt = cnt_q + 8'h01;
  assign body_done = take_body && (cnt_nxt == len_q);
  assign exec_d = (take_len && rx_data == 8'h00) || body_done;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_CMD: begin
        if (take_cmd) begin
          st_d = ST_LEN;
        end
      end
      ST_LEN: begin
        if (take_cmd) begin
          st_d = ST_LEN;
        end else if (take_len) begin
          st_d = (rx_data == 8'h00) ? ST_CMD : ST_BODY;
        end
      end
      ST_BODY: begin
        if (take_cmd) begin
          st_d = ST_LEN;
        end else if (body_done) begin
          st_d = ST_CMD;
        end
      end
      default: st_d = ST_CMD;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_CMD;
      cmd_q <= 8'h00;
      len_q <= 8'h00;
      cnt_q <= 8'h00;
      exec_q <= 1'b0;
      for (int i = 0; i < BODY_MAX; i++) begin
        body_q[i] <= 8'h00;
      end
    end else begin
      st_q <= st_d;
      exec_q <= exec_d;
      if (take_cmd) begin
        cmd_q <= rx_data;
      end
      if (take_len) begin
        len_q <= rx_data;
        cnt_q <= 8'h00;
      end
      if (take_body) begin
        cnt_q <= cnt_nxt;
        if (cnt_q < 8'(BODY_MAX)) begin
          body_q[cnt_q[1:0]] <= rx_data;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // command decode, evaluated in the cycle after the last byte
  // --------------------------------------------------------------------
  logic is_wr, is_rd, is_ps, wr_len_ok, wr_addr_ok, set_ptr, wr_val;
  logic rd_ok, ps_ok, len_err, ptr_we, rdr_we, ce_we, rdr_ld, ce_ld;
  logic [7:0] rdr_def, rep0, rep1, rd_data, rdr_val, ce_val;

  assign is_wr = cmd_q == CMD_REGISTER_WRITE_CMD;
  assign is_rd = cmd_q == CMD_RDREG;
  assign is_ps = cmd_q == CMD_PROTO;
  assign wr_len_ok = (len_q == LEN_SHORT) || (len_q == LEN_LONG);
  assign wr_addr_ok = body_q[0] == ADDR_WR;
  assign set_ptr = is_wr && wr_len_ok && wr_addr_ok && body_q[1] == FLAG_NOINC;
  assign wr_val = is_wr && len_q == LEN_LONG && wr_addr_ok && body_q[1] == FLAG_INC;
  assign ptr_we = exec_q && set_ptr && idx_ok(body_q[2]);
  assign rdr_we = exec_q && wr_val && body_q[2] == IDX_RDR;
  assign ce_we = exec_q && wr_val && body_q[2] == IDX_CE;
  assign rd_ok = is_rd && len_q == LEN_RD && body_q[0] == ADDR_RD;
  assign ps_ok = is_ps && len_q != 8'h00;
  assign len_err = (is_wr && !wr_len_ok) || (is_rd && len_q != LEN_RD) || (is_ps && !ps_ok);

  // protocol-select defaults
  assign rdr_ld = exec_q && ps_ok && (body_q[0] == PROTO_14443A || body_q[0] == PROTO_14443B
                  || body_q[0] == PROTO_18092 || body_q[0] == PROTO_15693);
  assign ce_ld = exec_q && ps_ok && body_q[0] == PROTO_CE_A;
  assign rdr_def = (body_q[0] == PROTO_14443A) ? DEF_RDR_A :
                   (body_q[0] == PROTO_14443B) ? DEF_RDR_B :
                   (body_q[0] == PROTO_18092) ? DEF_RDR_18092 :
                   (len_q > 8'h01 && body_q[1][PARAM_DEPTH100_BIT]) ? DEF_RDR_15693_100 :
                   DEF_RDR_15693_30;

  // reply bytes
  assign rep0 = len_err ? RES_ERR_LEN : (rd_ok ? RES_RD_TAG : RES_OK);
  assign rep1 = (rd_ok && !len_err) ? rd_data : RES_LEN_ZERO;

  acfg_regs u_regs (
    .ref_clk(ref_clk),
    .rst(rst),
    .rdr_ld(rdr_ld),
    .rdr_ld_val(rdr_def),
    .ce_ld(ce_ld),
    .ce_ld_val(DEF_CE_A),
    .rdr_we(rdr_we),
    .ce_we(ce_we),
    .wdata(body_q[3]),
    .sel(ptr_q),
    .rd_data(rd_data),
    .rdr_val(rdr_val),
    .ce_val(ce_val)
  );

  // --------------------------------------------------------------------
  // pointer, reply shifter and field outputs
  // --------------------------------------------------------------------
  logic tx_valid_q, tx_last_q, ph_q;
  logic [7:0] tx_data_q, hold_q, reader_cfg_q, card_cfg_q;
  logic [3:0] mod_q, gain_q, loadmod_q;
  logic [1:0] sens_q;
  logic [6:0] pct_q;
  logic [5:0] db_q;
  logic reply_go;

  assign reply_go = exec_q && (is_wr || is_rd || is_ps);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ptr_q <= IDX_RESET;
      tx_valid_q <= 1'b0;
      tx_last_q <= 1'b0;
      tx_data_q <= 8'h00;
      hold_q <= 8'h00;
      ph_q <= 1'b0;
    end else begin
      if (ptr_we) begin
        ptr_q <= body_q[2];
      end
      if (reply_go) begin
        tx_valid_q <= 1'b1;
        tx_last_q <= 1'b0;
        tx_data_q <= rep0;
        hold_q <= rep1;
        ph_q <= 1'b1;
      end else if (ph_q) begin
        tx_last_q <= 1'b1;
        tx_data_q <= hold_q;
        ph_q <= 1'b0;
      end else begin
        tx_valid_q <= 1'b0;
        tx_last_q <= 1'b0;
        tx_data_q <= 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reader_cfg_q <= 8'h00;
      card_cfg_q <= 8'h00;
      mod_q <= 4'h0;
      gain_q <= 4'h0;
      loadmod_q <= 4'h0;
      sens_q <= 2'h0;
      pct_q <= 7'd0;
      db_q <= 6'd0;
    end else begin
      reader_cfg_q <= rdr_val;
      card_cfg_q <= ce_val;
      mod_q <= rdr_val[MOD_LSB +: 4];
      gain_q <= rdr_val[GAIN_LSB +: 4];
      loadmod_q <= ce_val[LOADMOD_LSB +: 4];
      sens_q <= ce_val[SENS_LSB +: 2];
      pct_q <= mod_pct(rdr_val[MOD_LSB +: 4]);
      db_q <= gain_db(rdr_val[GAIN_LSB +: 4]);
    end
  end

  assign tx_valid = tx_valid_q;
  assign tx_last = tx_last_q;
  assign tx_data = tx_data_q;
  assign reader_cfg = reader_cfg_q;
  assign card_cfg = card_cfg_q;
  assign mod_index_code = mod_q;
  assign rx_gain_code = gain_q;
  assign load_mod_code = loadmod_q;
  assign demod_sens_code = sens_q;
  assign mod_percent = pct_q;
  assign rx_gain_db = db_q;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_ok_reply;
    tx_valid && !tx_last && tx_data == RES_OK ##1 tx_valid && tx_last && tx_data == RES_LEN_ZERO;
  endsequence

  a_ptr_set_index: assert property (ptr_we |=> ptr_q == $past(body_q[2]))
    else $error("pointer not set to written index");
  a_ptr_bad_index: assert property (exec_q && set_ptr && !idx_ok(body_q[2]) |=> $stable(ptr_q))
    else $error("pointer moved on invalid index");
  a_rdr_write_value: assert property (rdr_we |=> rdr_val == $past(body_q[3]))
    else $error("reader register not written");
  a_cfg_value_holds: assert property (!rdr_we && !rdr_ld |=> rdr_val == $past(rdr_val))
    else $error("reader register changed without cause");
  a_wr_ok_reply: assert property (exec_q && is_wr && wr_len_ok |=> s_ok_reply)
    else $error("write reply not 00 00");
  a_rd_reply_value: assert property (exec_q && rd_ok |=> tx_data == RES_RD_TAG ##1
    tx_last && tx_data == $past(rd_data, 2))
    else $error("read reply wrong");
  a_ce_default_load: assert property (ce_ld |=> ##1 card_cfg == DEF_CE_A && demod_sens_code == 2'h2)
    else $error("card default not loaded");
  a_rdr_default_a: assert property (rdr_ld && body_q[0] == PROTO_14443A |=> ##1
    reader_cfg == DEF_RDR_A && mod_percent == 7'd95)
    else $error("type A reader default not loaded");
endmodule
`default_nettype wire

/* File: sim/acfg_host_model.sv */
// host controller model: sends command frames, collects two-byte replies
`default_nettype none
module acfg_host_model
  import acfg_pkg::*;
(
  input wire logic ref_clk,
  output var logic rx_valid,
  output var logic rx_sof,
  output var logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic [7:0] tx_data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_data = 8'h00;
  end

  // ------------------------------------------------------------------
  // frame out, one byte per cycle
  // ------------------------------------------------------------------
  task automatic send(input logic [7:0] f[$]);
    for (int i = 0; i < f.size(); i++) begin
      @(posedge ref_clk);
      #1;
      rx_valid = 1'b1;
      rx_sof = (i == 0);
      rx_data = f[i];
    end
    @(posedge ref_clk);
    #1;
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    // released line: never leave the last byte standing
    rx_data = ~rx_data;
  endtask

  // ------------------------------------------------------------------
  // reply in, bounded wait
  // ------------------------------------------------------------------
  task automatic get_reply(output logic [7:0] b0, output logic [7:0] b1, output logic ok);
    int n;
    for (n = 0; n < 20 && tx_valid !== 1'b1; n++) begin
      @(negedge ref_clk);
    end
    b0 = tx_data;
    @(negedge ref_clk);
    b1 = tx_data;
    ok = (n < 20) && (tx_last === 1'b1);
  endtask
endmodule
`default_nettype wire

/* File: sim/tb_acfg_cmd_top.sv */
// self-checking bench for the analog configuration command interpreter
`default_nettype none
module tb_acfg_cmd_top
  import acfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk, rst, rx_valid, rx_sof, tx_valid, tx_last;
  logic [7:0] rx_data, tx_data, reader_cfg, card_cfg;
  logic [3:0] mod_index_code, rx_gain_code, load_mod_code;
  logic [1:0] demod_sens_code;
  logic [6:0] mod_percent;
  logic [5:0] rx_gain_db;
  int n_fail = 0;
  int num_checks = 0;
  logic [7:0] pcode[5] = '{PROTO_14443A, PROTO_14443B, PROTO_18092, PROTO_15693, PROTO_15693};
  logic [7:0] pparm[5] = '{8'h00, 8'h00, 8'h51, 8'h00, 8'h10};
  logic [7:0] pdef[5] = '{8'hdf, 8'h2f, 8'h5f, 8'h53, 8'hd3};
  logic [3:0] mcode[7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hd};
  logic [6:0] mpct[7] = '{7'd10, 7'd17, 7'd25, 7'd30, 7'd33, 7'd36, 7'd95};
  logic [3:0] gcode[7] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf, 4'h0, 4'h1};
  logic [5:0] gdb[7] = '{6'd34, 6'd32, 6'd27, 6'd20, 6'd8, 6'd34, 6'd32};
  // reader protocol that permits each modulation code of the sweep
  logic [7:0] mproto[7] = '{PROTO_14443B, PROTO_14443B, PROTO_18092, PROTO_18092, PROTO_15693, PROTO_15693,
    PROTO_14443A};
  logic [7:0] mdef[7] = '{DEF_RDR_B, DEF_RDR_B, DEF_RDR_18092, DEF_RDR_18092, DEF_RDR_15693_30,
    DEF_RDR_15693_30, DEF_RDR_A};

  acfg_cmd_top acfg_cmd_top_i (.ref_clk(ref_clk), .rst(rst), .rx_valid(rx_valid), .rx_sof(rx_sof),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_data(tx_data), .reader_cfg(reader_cfg),
    .card_cfg(card_cfg), .mod_index_code(mod_index_code), .rx_gain_code(rx_gain_code),
    .load_mod_code(load_mod_code), .demod_sens_code(demod_sens_code), .mod_percent(mod_percent),
    .rx_gain_db(rx_gain_db));

  acfg_host_model acfg_host_model_i (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_sof(rx_sof),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_data(tx_data));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] f[$], input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] b0, b1;
    logic ok;
    acfg_host_model_i.send(f);
    acfg_host_model_i.get_reply(b0, b1, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, ok, 1'b1);
      end_sim();
    end
    chk(b0, e0);
    chk(b1, e1);
  endtask

  task automatic point(input logic [7:0] idx);
    xfer('{CMD_REGISTER_WRITE_CMD, LEN_SHORT, ADDR_WR, FLAG_NOINC, idx}, RES_OK, RES_LEN_ZERO);
  endtask

  task automatic rd(input logic [7:0] exp);
    xfer('{CMD_RDREG, LEN_RD, ADDR_RD, 8'h01, 8'h00}, RES_RD_TAG, exp);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    xfer('{CMD_REGISTER_WRITE_CMD, LEN_LONG, ADDR_WR, FLAG_INC, idx, val}, RES_OK, RES_LEN_ZERO);
  endtask

  task automatic settle();
    repeat (3) @(negedge ref_clk);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    repeat (16) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    chk(reader_cfg, CFG_RESET);
    chk(card_cfg, CFG_RESET);
    point(IDX_RDR);
    rd(CFG_RESET);
    for (int i = 0; i < 5; i++) begin
      xfer('{CMD_PROTO, 8'h02, pcode[i], pparm[i]}, RES_OK, RES_LEN_ZERO);
      point(IDX_RDR);
      rd(pdef[i]);
      settle();
      chk(reader_cfg, pdef[i]);
    end
    xfer('{CMD_PROTO, 8'h02, PROTO_CE_A, 8'h08}, RES_OK, RES_LEN_ZERO);
    point(IDX_CE);
    rd(DEF_CE_A);
    settle();
    chk(card_cfg, DEF_CE_A);
    chk(reader_cfg, DEF_RDR_15693_100);
    // bits 7:6 kept zero on every card-emulation write
    wr(IDX_CE, 8'h25);
    point(IDX_CE);
    rd(8'h25);
    settle();
    chk({4'h0, load_mod_code}, 8'h05);
    chk({6'h00, demod_sens_code}, 8'h02);
    for (int i = 0; i < 7; i++) begin
      xfer('{CMD_PROTO, 8'h02, mproto[i], 8'h00}, RES_OK, RES_LEN_ZERO);
      point(IDX_RDR);
      rd(mdef[i]);
      wr(IDX_RDR, {mcode[i], gcode[i]});
      point(IDX_RDR);
      rd({mcode[i], gcode[i]});
      settle();
      chk({4'h0, mod_index_code}, {4'h0, mcode[i]});
      chk({4'h0, rx_gain_code}, {4'h0, gcode[i]});
      chk({1'b0, mod_percent}, {1'b0, mpct[i]});
      chk({2'b00, rx_gain_db}, {2'b00, gdb[i]});
    end
    point(IDX_RDR);
    rd(8'hd1);
    wr(8'h07, 8'h99);
    settle();
    chk(reader_cfg, 8'hd1);
    chk(card_cfg, 8'h25);
    // unknown index must leave the pointer where it was
    point(8'h07);
    rd(8'hd1);
    xfer('{CMD_REGISTER_WRITE_CMD, LEN_LONG, 8'h55, FLAG_INC, IDX_RDR, 8'h99}, RES_OK, RES_LEN_ZERO);
    xfer('{CMD_RDREG, LEN_RD, 8'h55, 8'h01, 8'h00}, RES_OK, RES_LEN_ZERO);
    settle();
    chk(reader_cfg, 8'hd1);
    xfer('{CMD_REGISTER_WRITE_CMD, 8'h02, ADDR_WR, FLAG_INC}, RES_ERR_LEN, RES_LEN_ZERO);
    settle();
    chk(card_cfg, 8'h25);
    xfer('{CMD_PROTO, 8'h02, PROTO_18092, 8'h51}, RES_OK, RES_LEN_ZERO);
    point(IDX_RDR);
    rd(DEF_RDR_18092);
    point(IDX_CE);
    rd(8'h25);
    // reset in mid-run stands for a power cycle
    @(posedge ref_clk);
    #1;
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(reader_cfg, CFG_RESET);
    chk(card_cfg, CFG_RESET);
    #1;
    rst = 1'b0;
    point(IDX_RDR);
    rd(CFG_RESET);
    point(IDX_CE);
    rd(CFG_RESET);
    end_sim();
  end
endmodule
`default_nettype wire
